// ### decode_defs.svh
`ifndef DECODE_DEFS_SVH
`define DECODE_DEFS_SVH

// The two-byte escape and the second opcode bytes that follow it.
`define OPC_ESCAPE        8'h0F
`define OPC_SET_NOT_NEG   8'h99
`define OPC_SET_OVERFLOW  8'h90
`define OPC_SET_NEG       8'h98
`define OPC_SET_PARITY    8'h9A
`define OPC_TABLE_STORE   8'h01
`define OPC_SELECTOR_STR  8'h00
`define OPC_DSHL_IMM      8'hA4
`define OPC_DSHL_CNT      8'hA5
`define OPC_DSHR_IMM      8'hAC
`define OPC_DSHR_CNT      8'hAD
`define OPC_MGMT_ENTRY    8'h7E

// Single-byte opcodes; the groups ignore the low width bit.
`define OPC_SET_CARRY     8'hF9
`define OPC_SET_DIR       8'hFD
`define OPC_SET_INTR      8'hFB
`define OPC_SHIFT_ONE     7'h68
`define OPC_SHIFT_CNT     7'h69
`define OPC_SHIFT_IMM     7'h60
`define OPC_STRING_STORE  7'h55

// ModR/M reg field values and position.
`define MODRM_REG_HI      5
`define MODRM_REG_LO      3
`define REG_000           3'h0
`define REG_001           3'h1
`define REG_SHL           3'h4
`define REG_SHR           3'h5

// Clock counts per variant.
`define CYC_SETCC         6'h01
`define CYC_TABLE_STORE   6'h04
`define CYC_LOCAL_SEL     6'h01
`define CYC_TASK_SEL      6'h04
`define CYC_SHIFT_ONE     6'h01
`define CYC_SHIFT_CNT     6'h02
`define CYC_SHIFT_IMM     6'h01
`define CYC_DSHIFT_IMM    6'h04
`define CYC_DSHIFT_CNT    6'h05
`define CYC_MGMT_ENTRY    6'h37
`define CYC_FLAG_SET      6'h01
`define CYC_STRING_STORE  6'h02

// Flag register reset value: all clear.
`define FLAGS_RESET       8'h00

`endif

// ### decode_pkg.sv
package decode_pkg;

    // One instruction as handed over by the fetch unit.
    typedef struct packed {
        logic       valid;      // Instruction present.
        logic       two_byte;   // First byte was the escape byte.
        logic [7:0] opcode;     // Opcode byte after any escape.
        logic [7:0] modrm;      // ModR/M byte.
        logic [7:0] imm8;       // Immediate count byte.
    } ins_in_t;

    // Status flags touched by this slice.
    typedef struct packed {
        logic overflow_flag;
        logic direction_flag;
        logic interrupt_flag;
        logic sign_flag;
        logic zero_flag;
        logic auxiliary_carry_flag;
        logic parity_flag;
        logic carry_flag;
    } flags_t;

    typedef enum logic [4:0] {
        OP_NONE                    = 5'h00,
        OP_SET_BYTE_NOT_NEGATIVE   = 5'h01,
        OP_SET_BYTE_OVERFLOWED     = 5'h02,
        OP_SET_BYTE_NEGATIVE       = 5'h03,
        OP_SET_BYTE_EVEN_PARITY    = 5'h04,
        OP_STORE_GLOBAL_TABLE_REG  = 5'h05,
        OP_STORE_INTR_TABLE_REG    = 5'h06,
        OP_STORE_LOCAL_TABLE_SEL   = 5'h07,
        OP_STORE_TASK_SELECTOR     = 5'h08,
        OP_LOGICAL_LEFT_SHIFT      = 5'h09,
        OP_LOGICAL_RIGHT_SHIFT     = 5'h0A,
        OP_DOUBLE_LEFT_SHIFT       = 5'h0B,
        OP_DOUBLE_RIGHT_SHIFT      = 5'h0C,
        OP_SOFTWARE_MGMT_ENTRY     = 5'h0D,
        OP_CARRY_FLAG_SET          = 5'h0E,
        OP_DIRECTION_FLAG_SET      = 5'h0F,
        OP_INTERRUPT_FLAG_SET      = 5'h10,
        OP_STRING_STORE            = 5'h11
    } op_t;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } state_t;

endpackage

// ### cycle_timer.sv
// Down-counter that flags the final cycle of a multi-clock operation.
module cycle_timer #(
    parameter int W = 6
) (
    input  wire logic         ref_clk,  // Core clock.
    input  wire logic         sys_rst,  // Synchronous reset, active high.
    input  wire logic         load,     // Start a new count.
    input  wire logic [W-1:0] load_val, // Clock count of the operation.
    output logic              last      // High in the operation's last cycle.
);
    logic [W-1:0] cnt_r;

    // The count runs down to zero and stays there until reloaded.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign last = (cnt_r == W'(1));
endmodule // cycle_timer

// ### setcc_shift_store_decode.sv
`include "decode_defs.svh"

// Behaviour
// RULE1: 0F 99 reg 000 set_byte_negative byte if sign clear, 1 clock, flags kept.
// RULE2: 0F 90 reg 000 set_byte_negative byte if overflow, 1 clock, flags kept.
// RULE3: 0F 98 reg 000 set_byte_negative byte if sign set, 1 clock, flags kept.
// RULE4: 0F 9A reg 000 set_byte_negative byte if parity even, 1 clock, flags kept.
// RULE5: 0F 01 reg 000 stores global table register, 4 clocks, flags kept.
// RULE6: 0F 01 reg 001 stores interrupt table register, 4 clocks, flags kept.
// RULE7: 0F 00 reg 000 stores local table selector, 1 clock, protected mode.
// RULE8: 0F 00 reg 001 stores task selector, 4 clocks, protected mode.
// RULE9: Shift group reg 100 is left shift; w selects width; by-one takes 1 clock.
// RULE10: Shifts by count register take 2 clocks; by immediate take 1 clock.
// RULE11: Reg 101 is right shift; set_byte_negative sign, zero, parity, carry; aux undefined.
// RULE12: Overflow defined only for single-bit shifts; otherwise undefined.
// RULE13: Double left shift: 0F A4 immediate 4 clocks, 0F A5 count 5 clocks.
// RULE14: Double right shift: AC 4, AD 5 clocks; overflow, aux undefined.
// RULE15: 0F 7E enters management mode in 55 clocks, flags kept.
// RULE16: FD set_byte_negative direction flag, F9 set_byte_negative carry flag.
// RULE17: FB set_byte_negative interrupt flag, other flags kept.
// RULE18: Protected-only instructions in real mode raise invalid opcode.
// RULE19: String store writes accumulator to index address, 2 clocks, flags kept.
module setcc_shift_store_decode
    import decode_pkg::*;
#(
    parameter int CW = 6
) (
    input  wire logic        ref_clk,        // Core clock, 100 MHz.
    input  wire logic        sys_rst,        // Synchronous reset, active high.
    input  wire ins_in_t     ins_i,          // Instruction from fetch.
    input  wire logic        protected_mode, // High in protected mode.
    input  wire logic [31:0] operand_a,      // Destination operand value.
    input  wire logic [31:0] operand_b,      // Fill source for double shifts.
    input  wire logic [7:0]  count_reg,      // Shift count register.
    input  wire logic [31:0] accumulator,    // Accumulator for string store.
    input  wire logic [31:0] dest_index,     // Destination index address.
    output logic             ins_ready_r,    // Ready to take an instruction.
    output op_t              op_r,           // Last completed operation.
    output logic             done_r,         // One-cycle completion pulse.
    output logic             invalid_op_r,   // One-cycle invalid opcode pulse.
    output logic [31:0]      result_r,       // Value to write back.
    output logic             wide_r,         // Opcode bit 0, the width bit of the shift and store groups.
    output logic [31:0]      store_addr_r,   // String store address.
    output logic [31:0]      index_next_r,   // Updated destination index.
    output flags_t           flags_r         // Status flags.
);

    state_t      state_r;
    op_t         dec_op;
    logic [CW-1:0] dec_cyc;
    logic        dec_ok;
    logic        dec_prot_only;
    logic        accept;
    logic        start;
    logic        last;

    op_t         pend_op_r;
    logic [31:0] pend_result_r;
    logic        pend_wide_r;
    flags_t      pend_flags_r;
    logic [31:0] pend_addr_r;
    logic [31:0] pend_index_r;

    logic [2:0]  reg_fld;
    logic        w_bit;
    logic        by_one;
    logic        by_count;
    logic [4:0]  sh_cnt;
    logic [31:0] a_masked;
    logic [63:0] lwide;
    logic [63:0] rwide;
    logic [64:0] dlwide;
    logic [64:0] drwide;
    logic [31:0] sh_res;
    logic        sh_cf;
    logic        sh_msb;
    flags_t      sh_flags;
    logic [31:0] nxt_result;
    flags_t      nxt_flags;
    logic [31:0] step;

    assign reg_fld = ins_i.modrm[`MODRM_REG_HI:`MODRM_REG_LO];
    assign w_bit   = ins_i.opcode[0];
    assign accept  = ins_i.valid && ins_ready_r;
    assign start   = accept && dec_ok;

    // Opcode and reg-field decode with per-variant clock counts.
    always_comb begin
        dec_op        = OP_NONE;
        dec_cyc       = CW'(0);
        dec_prot_only = 1'b0;
        by_one        = 1'b0;
        by_count      = 1'b0;
        if (ins_i.two_byte) begin
            case (ins_i.opcode)
                `OPC_SET_NOT_NEG: begin
                    if (reg_fld == `REG_000) begin
                        dec_op  = OP_SET_BYTE_NOT_NEGATIVE; // RULE1
                        dec_cyc = `CYC_SETCC;
                    end
                end
                `OPC_SET_OVERFLOW: begin
                    if (reg_fld == `REG_000) begin
                        dec_op  = OP_SET_BYTE_OVERFLOWED; // RULE2
                        dec_cyc = `CYC_SETCC;
                    end
                end
                `OPC_SET_NEG: begin
                    if (reg_fld == `REG_000) begin
                        dec_op  = OP_SET_BYTE_NEGATIVE; // RULE3
                        dec_cyc = `CYC_SETCC;
                    end
                end
                `OPC_SET_PARITY: begin
                    if (reg_fld == `REG_000) begin
                        dec_op  = OP_SET_BYTE_EVEN_PARITY; // RULE4
                        dec_cyc = `CYC_SETCC;
                    end
                end
                `OPC_TABLE_STORE: begin
                    if (reg_fld == `REG_000) begin
                        dec_op  = OP_STORE_GLOBAL_TABLE_REG; // RULE5
                        dec_cyc = `CYC_TABLE_STORE;
                    end else if (reg_fld == `REG_001) begin
                        dec_op  = OP_STORE_INTR_TABLE_REG; // RULE6
                        dec_cyc = `CYC_TABLE_STORE;
                    end
                end
                `OPC_SELECTOR_STR: begin
                    if (reg_fld == `REG_000) begin
                        dec_op        = OP_STORE_LOCAL_TABLE_SEL; // RULE7
                        dec_cyc       = `CYC_LOCAL_SEL;
                        dec_prot_only = 1'b1;
                    end else if (reg_fld == `REG_001) begin
                        dec_op        = OP_STORE_TASK_SELECTOR; // RULE8
                        dec_cyc       = `CYC_TASK_SEL;
                        dec_prot_only = 1'b1;
                    end
                end
                `OPC_DSHL_IMM: begin
                    dec_op  = OP_DOUBLE_LEFT_SHIFT; // RULE13
                    dec_cyc = `CYC_DSHIFT_IMM;
                end
                `OPC_DSHL_CNT: begin
                    dec_op   = OP_DOUBLE_LEFT_SHIFT; // RULE13
                    dec_cyc  = `CYC_DSHIFT_CNT;
                    by_count = 1'b1;
                end
                `OPC_DSHR_IMM: begin
                    dec_op  = OP_DOUBLE_RIGHT_SHIFT; // RULE14
                    dec_cyc = `CYC_DSHIFT_IMM;
                end
                `OPC_DSHR_CNT: begin
                    dec_op   = OP_DOUBLE_RIGHT_SHIFT; // RULE14
                    dec_cyc  = `CYC_DSHIFT_CNT;
                    by_count = 1'b1;
                end
                `OPC_MGMT_ENTRY: begin
                    dec_op  = OP_SOFTWARE_MGMT_ENTRY; // RULE15
                    dec_cyc = `CYC_MGMT_ENTRY;
                end
                default: begin
                    dec_op = OP_NONE;
                end
            endcase
        end else begin
            case (ins_i.opcode)
                `OPC_SET_CARRY: begin
                    dec_op  = OP_CARRY_FLAG_SET; // RULE16
                    dec_cyc = `CYC_FLAG_SET;
                end
                `OPC_SET_DIR: begin
                    dec_op  = OP_DIRECTION_FLAG_SET; // RULE16
                    dec_cyc = `CYC_FLAG_SET;
                end
                `OPC_SET_INTR: begin
                    dec_op  = OP_INTERRUPT_FLAG_SET; // RULE17
                    dec_cyc = `CYC_FLAG_SET;
                end
                default: begin
                    // Groups that carry the width in bit 0.
                    if (ins_i.opcode[7:1] == `OPC_STRING_STORE) begin
                        dec_op  = OP_STRING_STORE; // RULE19
                        dec_cyc = `CYC_STRING_STORE;
                    end else if ((reg_fld == `REG_SHL || reg_fld == `REG_SHR) &&
                                 (ins_i.opcode[7:1] == `OPC_SHIFT_ONE ||
                                  ins_i.opcode[7:1] == `OPC_SHIFT_CNT ||
                                  ins_i.opcode[7:1] == `OPC_SHIFT_IMM)) begin
                        dec_op = (reg_fld == `REG_SHL) ? OP_LOGICAL_LEFT_SHIFT  // RULE9
                                                       : OP_LOGICAL_RIGHT_SHIFT; // RULE11
                        if (ins_i.opcode[7:1] == `OPC_SHIFT_ONE) begin
                            dec_cyc = `CYC_SHIFT_ONE; // RULE9
                            by_one  = 1'b1;
                        end else if (ins_i.opcode[7:1] == `OPC_SHIFT_CNT) begin
                            dec_cyc  = `CYC_SHIFT_CNT; // RULE10
                            by_count = 1'b1;
                        end else begin
                            dec_cyc = `CYC_SHIFT_IMM; // RULE10
                        end
                    end
                end
            endcase
        end
    end

    // Protected-only selector stores are refused outside protected mode.
    assign dec_ok = (dec_op != OP_NONE) && !(dec_prot_only && !protected_mode); // RULE18

    // Shift datapath. Double shifts are always 32 bits wide; counts wrap mod 32.
    always_comb begin
        sh_cnt   = by_one ? 5'h01 : (by_count ? count_reg[4:0] : ins_i.imm8[4:0]);
        a_masked = (w_bit || dec_op == OP_DOUBLE_LEFT_SHIFT || dec_op == OP_DOUBLE_RIGHT_SHIFT)
                   ? operand_a : {24'h000000, operand_a[7:0]};
        lwide    = {32'h00000000, a_masked} << sh_cnt;
        rwide    = {a_masked, 32'h00000000} >> sh_cnt;
        dlwide   = {1'b0, operand_a, operand_b} << sh_cnt;
        drwide   = {operand_b, operand_a, 1'b0} >> sh_cnt;
        sh_res   = 32'h00000000;
        sh_cf    = 1'b0;
        case (dec_op)
            OP_LOGICAL_LEFT_SHIFT: begin
                sh_res = w_bit ? lwide[31:0] : {24'h000000, lwide[7:0]};
                sh_cf  = w_bit ? lwide[32] : lwide[8];
            end
            OP_LOGICAL_RIGHT_SHIFT: begin
                sh_res = rwide[63:32];
                sh_cf  = rwide[31];
            end
            OP_DOUBLE_LEFT_SHIFT: begin
                sh_res = dlwide[63:32];
                sh_cf  = dlwide[64];
            end
            OP_DOUBLE_RIGHT_SHIFT: begin
                sh_res = drwide[32:1];
                sh_cf  = drwide[0];
            end
            default: begin
                sh_res = 32'h00000000;
            end
        endcase
        sh_msb = (w_bit || dec_op == OP_DOUBLE_LEFT_SHIFT || dec_op == OP_DOUBLE_RIGHT_SHIFT)
                 ? sh_res[31] : sh_res[7];
        // Undefined flags keep their old value, the cheapest legal choice.
        sh_flags            = flags_r;
        if (sh_cnt != 5'h00) begin
            sh_flags.sign_flag   = sh_msb; // RULE11
            sh_flags.zero_flag   = (sh_res == 32'h00000000); // RULE11
            sh_flags.parity_flag = ~^sh_res[7:0]; // RULE11
            sh_flags.carry_flag  = sh_cf; // RULE11
            if (by_one) begin
                // Left: top bit differs from carry; right: original top bit.
                sh_flags.overflow_flag = (dec_op == OP_LOGICAL_LEFT_SHIFT)
                                         ? (sh_msb ^ sh_cf)
                                         : (w_bit ? operand_a[31] : operand_a[7]); // RULE12
            end
        end
    end

    // Result and flag image for every operation.
    always_comb begin
        nxt_result = 32'h00000000;
        nxt_flags  = flags_r;
        step       = w_bit ? 32'h00000004 : 32'h00000001;
        case (dec_op)
            OP_SET_BYTE_NOT_NEGATIVE: nxt_result = {31'h0, ~flags_r.sign_flag}; // RULE1
            OP_SET_BYTE_OVERFLOWED:   nxt_result = {31'h0, flags_r.overflow_flag}; // RULE2
            OP_SET_BYTE_NEGATIVE:     nxt_result = {31'h0, flags_r.sign_flag}; // RULE3
            OP_SET_BYTE_EVEN_PARITY:  nxt_result = {31'h0, flags_r.parity_flag}; // RULE4
            OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
            OP_DOUBLE_LEFT_SHIFT, OP_DOUBLE_RIGHT_SHIFT: begin
                nxt_result = sh_res;
                nxt_flags  = sh_flags;
            end
            OP_CARRY_FLAG_SET:     nxt_flags.carry_flag     = 1'b1; // RULE16
            OP_DIRECTION_FLAG_SET: nxt_flags.direction_flag = 1'b1; // RULE16
            OP_INTERRUPT_FLAG_SET: nxt_flags.interrupt_flag = 1'b1; // RULE17
            OP_STRING_STORE: begin
                nxt_result = w_bit ? accumulator : {24'h000000, accumulator[7:0]}; // RULE19
            end
            default: begin
                nxt_result = 32'h00000000;
            end
        endcase
    end

    cycle_timer #(
        .W (CW)
    ) u_timer (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .load     (start),
        .load_val (dec_cyc),
        .last     (last)
    );

    // Sequencer: one instruction at a time, held for its clock count.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            ins_ready_r <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r     <= ST_BUSY;
                        ins_ready_r <= 1'b0;
                    end
                end
                ST_BUSY: begin
                    if (last) begin
                        state_r     <= ST_IDLE;
                        ins_ready_r <= 1'b1;
                    end
                end
                default: begin
                    state_r     <= ST_IDLE;
                    ins_ready_r <= 1'b1;
                end
            endcase
        end
    end

    // Capture the outcome when the instruction is taken.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_op_r     <= OP_NONE;
            pend_result_r <= 32'h00000000;
            pend_wide_r   <= 1'b0;
            pend_flags_r  <= `FLAGS_RESET;
            pend_addr_r   <= 32'h00000000;
            pend_index_r  <= 32'h00000000;
        end else if (start) begin
            pend_op_r     <= dec_op;
            pend_result_r <= nxt_result;
            pend_wide_r   <= w_bit;
            pend_flags_r  <= nxt_flags;
            pend_addr_r   <= dest_index; // RULE19
            pend_index_r  <= flags_r.direction_flag ? (dest_index - step) : (dest_index + step);
        end
    end

    // Commit at the end of the clock count so results track the timing.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_r         <= OP_NONE;
            done_r       <= 1'b0;
            result_r     <= 32'h00000000;
            wide_r       <= 1'b0;
            store_addr_r <= 32'h00000000;
            index_next_r <= 32'h00000000;
            flags_r      <= `FLAGS_RESET;
        end else begin
            done_r <= (state_r == ST_BUSY) && last;
            if ((state_r == ST_BUSY) && last) begin
                op_r         <= pend_op_r;
                result_r     <= pend_result_r;
                wide_r       <= pend_wide_r;
                store_addr_r <= pend_addr_r;
                index_next_r <= pend_index_r;
                flags_r      <= pend_flags_r;
            end
        end
    end

    // Unknown opcodes and real-mode selector stores are reported, not run.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            invalid_op_r <= 1'b0;
        end else begin
            invalid_op_r <= accept && !dec_ok; // RULE18
        end
    end

endmodule // setcc_shift_store_decode

// ### decode_checker.sv
module decode_checker
    import decode_pkg::*;
(
    input  wire logic    ref_clk,        // Core clock.
    input  wire logic    sys_rst,        // Synchronous reset.
    input  wire ins_in_t ins_i,          // Instruction from fetch.
    input  wire logic    protected_mode, // Mode select.
    input  wire logic    ins_ready_r,    // Ready to accept.
    input  wire op_t     op_r,           // Last completed operation.
    input  wire logic    done_r,         // Completion pulse.
    input  wire logic    invalid_op_r,   // Refusal pulse.
    input  wire flags_t  flags_r         // Status flags.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Accept strobes and the reg field, shared by most properties.
    logic       acc;
    logic       esc;
    logic [2:0] rg;
    assign acc = ins_i.valid && ins_ready_r;
    assign esc = acc && ins_i.two_byte;
    assign rg  = ins_i.modrm[5:3];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_accept_answer: assert property (acc |=> invalid_op_r || !ins_ready_r)
        else $error("Accepted instruction did not start");
    a_global_table_four: assert property (esc && ins_i.opcode == 8'h01 && rg == 3'h0
        |=> !done_r [*4] ##1 done_r && op_r == OP_STORE_GLOBAL_TABLE_REG)
        else $error("Global table store timing wrong");
    a_task_sel_four: assert property (esc && ins_i.opcode == 8'h00 && rg == 3'h1
        && protected_mode |=> !done_r [*4] ##1 done_r && op_r == OP_STORE_TASK_SELECTOR)
        else $error("Task selector store timing wrong");
    a_dshift_count_five: assert property (esc && ins_i.opcode inside {8'hA5, 8'hAD}
        |=> !done_r [*5] ##1 done_r)
        else $error("Double shift by count timing wrong");
    a_mgmt_entry_time: assert property (esc && ins_i.opcode == 8'h7E
        |-> ##56 done_r && op_r == OP_SOFTWARE_MGMT_ENTRY)
        else $error("Management entry timing wrong");
    a_setcc_flags_kept: assert property (esc && rg == 3'h0
        && ins_i.opcode inside {8'h90, 8'h98, 8'h99, 8'h9A}
        |=> ##1 done_r && flags_r == $past(flags_r, 2))
        else $error("Conditional set changed flags");
    a_carry_set_op: assert property (acc && !ins_i.two_byte && ins_i.opcode == 8'hF9
        |=> ##1 done_r && flags_r.carry_flag)
        else $error("Carry flag not set");
    a_real_mode_refuse: assert property (esc && ins_i.opcode == 8'h00 && rg < 3'h2
        && !protected_mode |=> invalid_op_r && !done_r)
        else $error("Real mode selector store not refused");
endmodule // decode_checker

bind setcc_shift_store_decode decode_checker i_decode_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ins_i(ins_i), .protected_mode(protected_mode),
    .ins_ready_r(ins_ready_r), .op_r(op_r), .done_r(done_r),
    .invalid_op_r(invalid_op_r), .flags_r(flags_r)
);

// ### fetch_model.sv
module fetch_model
    import decode_pkg::*;
(
    input  wire logic ref_clk,     // Core clock.
    input  wire logic ins_ready_r, // Decoder ready.
    output ins_in_t   ins_o        // Instruction to the decoder.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus starts low.
    initial ins_o = '0;

    // Hold one instruction until an edge sees ready; released fields go inverted,
    // so a late read of them sees garbage, not old data.
    task automatic send(input ins_in_t v);
        ins_o = v;
        while (ins_ready_r !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        ins_o = {1'b0, ~v[$bits(v)-2:0]};
    endtask
endmodule // fetch_model

// ### testbench.sv
module testbench
    import decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %0h want %0h", $time, a, b); end end

    logic        ref_clk, sys_rst, protected_mode, ins_ready_r, done_r, invalid_op_r, wide_r;
    logic [31:0] operand_a, operand_b, accumulator, dest_index;
    logic [31:0] result_r, store_addr_r, index_next_r;
    logic [7:0]  count_reg;
    ins_in_t     ins_i;
    op_t         op_r;
    flags_t      flags_r, saved;
    int          bad_count, checks, cyc, n;

    setcc_shift_store_decode i_setcc_shift_store_decode (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ins_i(ins_i), .protected_mode(protected_mode), .operand_a(operand_a),
        .operand_b(operand_b), .count_reg(count_reg), .accumulator(accumulator),
        .dest_index(dest_index), .ins_ready_r(ins_ready_r), .op_r(op_r), .done_r(done_r),
        .invalid_op_r(invalid_op_r), .result_r(result_r), .wide_r(wide_r),
        .store_addr_r(store_addr_r), .index_next_r(index_next_r), .flags_r(flags_r));
    fetch_model i_fetch_model (.ref_clk(ref_clk), .ins_ready_r(ins_ready_r), .ins_o(ins_i));

    // Free-running clock.
    always #5 ref_clk = ~ref_clk;

    // Cut a hang short; the run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Counts: %0d mismatches in %0d comparisons", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Issue one instruction, count edges to done or refusal, check both.
    task automatic run(input logic tb, input logic [7:0] opc, mr, im, input op_t eop,
                       input int ne, input logic inv);
        i_fetch_model.send({1'b1, tb, opc, mr, im});
        n = 0;
        while (!done_r && !invalid_op_r && n < 99) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n, ne)
        `CHK(invalid_op_r, inv)
        `CHK(op_r, eop)
    endtask

    // Main sequence; each call starts just after an edge.
    initial begin : main
        logic [7:0] sc_opc [4];
        op_t        sc_op [4];
        sc_opc = '{8'h99, 8'h98, 8'h90, 8'h9A};
        sc_op = '{OP_SET_BYTE_NOT_NEGATIVE, OP_SET_BYTE_NEGATIVE, OP_SET_BYTE_OVERFLOWED,
                  OP_SET_BYTE_EVEN_PARITY};
        {ref_clk, sys_rst, protected_mode} = 3'b011;
        {operand_a, operand_b, accumulator, dest_index, count_reg} = '0;
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        `CHK({ins_ready_r, done_r, flags_r}, 10'h200)
        run(0, 8'hF9, 8'h00, 8'h00, OP_CARRY_FLAG_SET, 1, 0);
        run(0, 8'hFD, 8'h00, 8'h00, OP_DIRECTION_FLAG_SET, 1, 0);
        run(0, 8'hFB, 8'h00, 8'h00, OP_INTERRUPT_FLAG_SET, 1, 0);
        `CHK(flags_r, 8'h61)
        operand_a = 32'h40;
        run(0, 8'hD0, 8'hE0, 8'h00, OP_LOGICAL_LEFT_SHIFT, 1, 0);
        `CHK({result_r[7:0], wide_r, flags_r}, 17'h1_00F0)
        saved = flags_r;
        for (int i = 0; i < 4; i++) begin
            run(1, sc_opc[i], 8'hC0, 8'h00, sc_op[i], 1, 0);
            `CHK({result_r, flags_r}, {31'h0, (i == 1 || i == 2), saved})
        end
        operand_a = 32'hF8;
        run(0, 8'hC1, 8'hE8, 8'h04, OP_LOGICAL_RIGHT_SHIFT, 1, 0);
        `CHK({result_r, wide_r, flags_r}, {32'hF, 1'b1, 8'hE3})
        run(1, 8'h9A, 8'hC0, 8'h00, OP_SET_BYTE_EVEN_PARITY, 1, 0);
        `CHK(result_r, 32'h1)
        operand_a = 32'hC000_0001;
        count_reg = 8'h02;
        run(0, 8'hD3, 8'hE0, 8'h00, OP_LOGICAL_LEFT_SHIFT, 2, 0);
        `CHK({result_r, flags_r.carry_flag}, {32'h4, 1'b1})
        operand_a = 32'hFF;
        operand_b = 32'hF000_000F;
        count_reg = 8'h04;
        run(1, 8'hA4, 8'hC0, 8'h04, OP_DOUBLE_LEFT_SHIFT, 4, 0);
        `CHK(result_r, 32'hFFF)
        run(1, 8'hA5, 8'hC0, 8'h00, OP_DOUBLE_LEFT_SHIFT, 5, 0);
        run(1, 8'hAC, 8'hC0, 8'h04, OP_DOUBLE_RIGHT_SHIFT, 4, 0);
        `CHK({result_r, flags_r.sign_flag, flags_r.carry_flag}, {32'hF000_000F, 2'b11})
        run(1, 8'hAD, 8'hC0, 8'h00, OP_DOUBLE_RIGHT_SHIFT, 5, 0);
        run(1, 8'h01, 8'h00, 8'h00, OP_STORE_GLOBAL_TABLE_REG, 4, 0);
        run(1, 8'h01, 8'h08, 8'h00, OP_STORE_INTR_TABLE_REG, 4, 0);
        run(1, 8'h00, 8'hC0, 8'h00, OP_STORE_LOCAL_TABLE_SEL, 1, 0);
        run(1, 8'h00, 8'hC8, 8'h00, OP_STORE_TASK_SELECTOR, 4, 0);
        protected_mode = 1'b0;
        run(1, 8'h00, 8'hC0, 8'h00, OP_STORE_TASK_SELECTOR, 0, 1);
        run(0, 8'hD0, 8'hF0, 8'h00, OP_STORE_TASK_SELECTOR, 0, 1);
        run(1, 8'h7E, 8'h00, 8'h00, OP_SOFTWARE_MGMT_ENTRY, 55, 0);
        saved = flags_r;
        accumulator = 32'hA5A5_1234;
        dest_index = 32'h100;
        run(0, 8'hAB, 8'h00, 8'h00, OP_STRING_STORE, 2, 0);
        `CHK({result_r, store_addr_r}, 64'hA5A5_1234_0000_0100)
        `CHK({index_next_r, flags_r}, {32'hFC, saved})
        print_verdict();
    end
endmodule // testbench
